// File: src/seq_device.sv
// Summary of operation
// R1: Code 30 runs stored table once.
// R2: Code 31 runs supplied table once.
// R3: Code 32 repeats stored table.
// R4: Code 33 repeats supplied table.
// R5: Coils 240/241 or code 17 fast-stop.
// R6: Coils 244/245 or code 18 decelerated stop.
// R7: Coils 340/344 run stored table once.
// R8: Coils 341/345 repeat stored table.
// R9: Coils 342/346 run supplied table once.
// R10: Coils 343/347 repeat supplied table.
// R11: Host writes table into holding registers 500-1500.
// R12: Supplied table overrides stored table.
// R13: Stored table starts automatically at power-up.
// R14: Single cycle runs every profile once.
// R15: Repeat ends on stop or fault.
// R16: Last profile of repeated table stops.
// R17: Profile holds accel, decel, velocity, target.
// R18: Dwell separates positioning and speed profiles.
// R19: Entry carries kind, direction, cycle, shapes, rotation.
// R20: Absolute targets measured from zero.
// R21: Later incremental targets add to position.
// R22: Motion starts from common initial velocity.
// R23: Start outside standby gives command error.
// R24: Each axis has its own sequencer.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"
module seq_device #(
  parameter int DEPTH = 1001,
  parameter int VW    = 16
) (
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  seq_link_if.dev                        link,
  input  wire logic [VW-1:0]             init_velocity,
  input  wire logic [1:0]                startup_run,
  input  wire logic [1:0]                fault_pin,
  input  wire logic [1:0]                pg_done,
  output logic      [1:0]                pg_start,
  output logic      [1:0]                pg_stop_fast,
  output logic      [1:0]                pg_stop_dec,
  output logic      [1:0][15:0]          pg_accel,
  output logic      [1:0][15:0]          pg_decel,
  output logic      [1:0][15:0]          pg_vel,
  output logic      [1:0][VW-1:0]        pg_init_vel,
  output logic      [1:0][31:0]          pg_target,
  output logic      [1:0][`FLAG_W-1:0]   pg_flags
);
  import seq_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [15:0]        stored_mem [DEPTH];
  logic [15:0]        supp_mem   [DEPTH];
  logic [AW-1:0]      widx;
  logic [1:0]         fault_s1_reg;
  logic [1:0]         fault_s2_reg;
  logic               boot_reg;
  cmd_dec_t           dec;
  seq_state_t         state_reg  [2];
  logic [AW-1:0]      prof_reg   [2];
  logic [AW-1:0]      cnt_reg    [2];
  logic [2:0]         word_reg   [2];
  logic [15:0]        ent_reg    [2][6];
  logic               rep_reg    [2];
  logic               supp_reg   [2];
  logic               first_reg  [2];
  logic               prev_v_reg [2];
  logic               prev_spd_reg [2];
  logic signed [31:0] pos_reg    [2];
  logic [15:0]        dwell_reg  [2];

  assign widx = AW'(link.tbl_addr - `HREG_FIRST);
  assign dec  = decode_cmd(link.cmd_coil, link.cmd_code, link.cmd_axis);

  // Table read from the selected copy
  function automatic logic [15:0] rd(input logic sel, input logic [AW-1:0] i);
    return sel ? supp_mem[i] : stored_mem[i];  // R12
  endfunction

  function automatic logic [AW-1:0] waddr(input logic [AW-1:0] p, input logic [2:0] w);
    return AW'(32'h1 + 32'(p) * 32'(`ENTRY_WORDS) + 32'(w));
  endfunction

  // Table storage
  always_ff @(posedge clk_sys) begin
    if (link.tbl_we && link.tbl_addr >= `HREG_FIRST && link.tbl_addr <= `HREG_LAST) begin  // R11
      if (link.tbl_store) begin
        stored_mem[widx] <= link.tbl_data;
      end else begin
        supp_mem[widx] <= link.tbl_data;
      end
    end
  end

  // Fault pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fault_s1_reg <= 2'h0;
      fault_s2_reg <= 2'h0;
    end else begin
      fault_s1_reg <= fault_pin;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  // Power-up start window
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // Standby report
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link.standby_flag <= 2'h0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        link.standby_flag[a] <= (state_reg[a] == S_IDLE);
      end
    end
  end

  // Sequencers, one per axis
  always_ff @(posedge clk_sys) begin : seq_p
    logic               run_q;
    logic               fast_q;
    logic               dec_q;
    logic               nsel;
    logic [15:0]        w;
    logic signed [31:0] raw;
    run_q  = 1'b0;
    fast_q = 1'b0;
    dec_q  = 1'b0;
    nsel   = 1'b0;
    w      = 16'h0000;
    raw    = 32'h0000_0000;
    if (srst) begin
      link.cmd_err  <= 1'b0;
      link.seq_done <= 2'h0;
      pg_start      <= 2'h0;
      pg_stop_fast  <= 2'h0;
      pg_stop_dec   <= 2'h0;
      pg_accel      <= '0;
      pg_decel      <= '0;
      pg_vel        <= '0;
      pg_init_vel   <= '0;
      pg_target     <= '0;
      pg_flags      <= '0;
      for (int a = 0; a < 2; a++) begin
        state_reg[a]    <= S_IDLE;
        prof_reg[a]     <= '0;
        cnt_reg[a]      <= '0;
        word_reg[a]     <= 3'h0;
        rep_reg[a]      <= 1'b0;
        supp_reg[a]     <= 1'b0;
        first_reg[a]    <= 1'b0;
        prev_v_reg[a]   <= 1'b0;
        prev_spd_reg[a] <= 1'b0;
        pos_reg[a]      <= 32'h0000_0000;
        dwell_reg[a]    <= 16'h0000;
        for (int k = 0; k < 6; k++) begin
          ent_reg[a][k] <= 16'h0000;
        end
      end
    end else begin
      link.cmd_err <= 1'b0;
      for (int a = 0; a < 2; a++) begin  // R24
        pg_start[a]      <= 1'b0;
        pg_stop_fast[a]  <= 1'b0;
        pg_stop_dec[a]   <= 1'b0;
        link.seq_done[a] <= 1'b0;
        run_q  = (link.cmd_valid && dec.op == OP_RUN && dec.axis == a[0]) || (boot_reg && startup_run[a]);  // R13
        nsel   = boot_reg ? 1'b0 : dec.supplied;
        fast_q = (link.cmd_valid && dec.op == OP_FAST && dec.axis == a[0]) || fault_s2_reg[a];  // R5
        dec_q  = link.cmd_valid && dec.op == OP_DEC && dec.axis == a[0];  // R6
        if (run_q && (state_reg[a] != S_IDLE || fault_s2_reg[a])) begin
          link.cmd_err <= 1'b1;  // R23
        end
        if (state_reg[a] != S_IDLE && state_reg[a] != S_STOP && (fast_q || dec_q)) begin  // R15
          if (state_reg[a] == S_MOVE) begin
            pg_stop_fast[a] <= fast_q;
            pg_stop_dec[a]  <= !fast_q;
            state_reg[a]    <= S_STOP;
          end else begin
            state_reg[a] <= S_IDLE;
          end
        end else begin
          case (state_reg[a])
            S_IDLE: begin
              if (run_q && !fault_s2_reg[a]) begin  // R1 R2 R3 R4 R7 R8 R9 R10
                rep_reg[a]    <= boot_reg ? 1'b0 : dec.repeat_en;
                supp_reg[a]   <= nsel;  // R12
                prof_reg[a]   <= '0;
                word_reg[a]   <= 3'h0;
                first_reg[a]  <= 1'b1;
                prev_v_reg[a] <= 1'b0;
                state_reg[a]  <= S_LOAD;
              end
            end
            S_LOAD: begin
              w = rd(supp_reg[a], '0);
              cnt_reg[a] <= w[AW-1:0];
              if (w[AW-1:0] == '0) begin
                link.seq_done[a] <= 1'b1;
                state_reg[a]     <= S_IDLE;
              end else begin
                state_reg[a] <= S_FETCH;
              end
            end
            S_FETCH: begin
              w = rd(supp_reg[a], waddr(prof_reg[a], word_reg[a]));
              ent_reg[a][word_reg[a]] <= w;  // R17 R19
              if (word_reg[a] == `ENTRY_WORDS - 3'h1) begin
                word_reg[a] <= 3'h0;
                if (prev_v_reg[a] && prev_spd_reg[a] != w[`F_SPEED]) begin  // R18
                  dwell_reg[a] <= 16'(`DWELL_CYC);
                  state_reg[a] <= S_DWELL;
                end else begin
                  state_reg[a] <= S_ISSUE;
                end
              end else begin
                word_reg[a] <= word_reg[a] + 3'h1;
              end
            end
            S_DWELL: begin
              if (dwell_reg[a] <= 16'h0001) begin  // R18
                state_reg[a] <= S_ISSUE;
              end else begin
                dwell_reg[a] <= dwell_reg[a] - 16'h0001;
              end
            end
            S_ISSUE: begin
              w   = ent_reg[a][`W_FLAGS];
              raw = {ent_reg[a][`W_TGT_HI], ent_reg[a][`W_TGT_LO]};  // R20
              if (!w[`F_SPEED] && w[`F_POS_INC] && !first_reg[a]) begin
                raw = pos_reg[a] + raw;  // R21
              end
              pos_reg[a]      <= raw;
              pg_target[a]    <= raw;
              pg_accel[a]     <= ent_reg[a][`W_ACCEL];  // R17
              pg_decel[a]     <= ent_reg[a][`W_DECEL];
              pg_vel[a]       <= ent_reg[a][`W_VEL];
              pg_flags[a]     <= w[`FLAG_W-1:0];  // R19
              pg_init_vel[a]  <= init_velocity;  // R22
              pg_start[a]     <= 1'b1;
              first_reg[a]    <= 1'b0;
              prev_v_reg[a]   <= 1'b1;
              prev_spd_reg[a] <= w[`F_SPEED];
              state_reg[a]    <= S_MOVE;
            end
            S_MOVE: begin
              if (pg_done[a]) begin
                if (prof_reg[a] + 1'b1 == cnt_reg[a]) begin
                  prof_reg[a] <= '0;
                  if (rep_reg[a]) begin  // R15
                    first_reg[a] <= 1'b1;
                    state_reg[a] <= S_FETCH;
                  end else begin
                    link.seq_done[a] <= 1'b1;  // R14
                    state_reg[a]     <= S_IDLE;
                  end
                end else begin
                  prof_reg[a]  <= prof_reg[a] + 1'b1;  // R14
                  state_reg[a] <= S_FETCH;
                end
              end
            end
            S_STOP: begin
              if (pg_done[a]) begin
                state_reg[a] <= S_IDLE;
              end
            end
            default: begin
              state_reg[a] <= S_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule // seq_device
`default_nettype wire

// File: src/seq_cfg.svh
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// Controller command codes
`define CMD_ONCE_STORED   10'h01E
`define CMD_REP_SUPPLIED  10'h021
`define CMD_FAST_STOP     10'h011
`define CMD_DEC_STOP      10'h012

// Host coil numbers
`define COIL_FAST_A       10'h0F0
`define COIL_FAST_B       10'h0F1
`define COIL_DEC_A        10'h0F4
`define COIL_DEC_B        10'h0F5
`define COIL_RUN_FIRST    10'h154
`define COIL_RUN_LAST     10'h15B

// Holding register window of the table
`define HREG_FIRST        11'h1F4
`define HREG_LAST         11'h5DC

// Table entry layout, word 0 of the table is the profile count
`define W_ACCEL           3'h0
`define W_DECEL           3'h1
`define W_VEL             3'h2
`define W_TGT_LO          3'h3
`define W_TGT_HI          3'h4
`define W_FLAGS           3'h5
`define ENTRY_WORDS       3'h6

// Flag bits of an entry
`define F_SPEED           0
`define F_DIR_REV         1
`define F_CONT            2
`define F_ACC_S           3
`define F_DEC_S           4
`define F_ROT_SHORT       5
`define F_POS_INC         6
`define FLAG_W            7

// Host register offsets and fields
`define ADDR_CMD          8'h00
`define ADDR_TBL          8'h04
`define ADDR_STAT         8'h08
`define CMD_COIL_BIT      10
`define CMD_AXIS_BIT      11
`define TBL_ADDR_LSB      16
`define TBL_ADDR_MSB      26
`define TBL_STORE_BIT     27
`define STAT_CMD_ERR      2
`define STAT_RANGE_ERR    3
`define STAT_DONE_LSB     4

// Timing
`define CLK_NS            20
`define DWELL_NS          1000
`define DWELL_CYC         ((`DWELL_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: src/seq_pkg.sv
`default_nettype none
`include "seq_cfg.svh"
package seq_pkg;

  typedef enum logic [1:0] {OP_NONE, OP_RUN, OP_FAST, OP_DEC} op_t;

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_FETCH, S_DWELL, S_ISSUE, S_MOVE, S_STOP} seq_state_t;

  typedef struct packed {
    op_t  op;
    logic axis;
    logic supplied;
    logic repeat_en;
  } cmd_dec_t;

  // Maps a controller code or a host coil onto an operation
  function automatic cmd_dec_t decode_cmd(input logic coil, input logic [9:0] code, input logic axis);
    cmd_dec_t   d;
    logic [9:0] off;
    d   = '{op: OP_NONE, axis: axis, supplied: 1'b0, repeat_en: 1'b0};
    off = 10'h000;
    if (coil) begin
      if (code == `COIL_FAST_A || code == `COIL_FAST_B) begin
        d.op   = OP_FAST;
        d.axis = code[0];
      end else if (code == `COIL_DEC_A || code == `COIL_DEC_B) begin
        d.op   = OP_DEC;
        d.axis = code[0];
      end else if (code >= `COIL_RUN_FIRST && code <= `COIL_RUN_LAST) begin
        off         = code - `COIL_RUN_FIRST;
        d.op        = OP_RUN;
        d.axis      = off[2];
        d.supplied  = off[1];
        d.repeat_en = off[0];
      end
    end else begin
      if (code >= `CMD_ONCE_STORED && code <= `CMD_REP_SUPPLIED) begin
        off         = code - `CMD_ONCE_STORED;
        d.op        = OP_RUN;
        d.supplied  = off[0];
        d.repeat_en = off[1];
      end else if (code == `CMD_FAST_STOP) begin
        d.op = OP_FAST;
      end else if (code == `CMD_DEC_STOP) begin
        d.op = OP_DEC;
      end
    end
    return d;
  endfunction

endpackage
`default_nettype wire

// File: src/seq_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seq_link_if;
  logic        cmd_valid;
  logic [9:0]  cmd_code;
  logic        cmd_coil;
  logic        cmd_axis;
  logic        tbl_we;
  logic [10:0] tbl_addr;
  logic [15:0] tbl_data;
  logic        tbl_store;
  logic [1:0]  standby_flag;
  logic        cmd_err;
  logic [1:0]  seq_done;

  modport dev (
    input  cmd_valid, cmd_code, cmd_coil, cmd_axis, tbl_we, tbl_addr, tbl_data, tbl_store,
    output standby_flag, cmd_err, seq_done
  );

  modport host (
    output cmd_valid, cmd_code, cmd_coil, cmd_axis, tbl_we, tbl_addr, tbl_data, tbl_store,
    input  standby_flag, cmd_err, seq_done
  );
endinterface
`default_nettype wire

// File: src/seq_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"
module seq_host (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  seq_link_if.host         link
);
  import seq_pkg::*;

  logic        setup;
  logic        wr;
  logic [10:0] taddr;
  logic        in_range;
  logic        last_flags;
  logic [15:0] count_reg;
  logic        cmd_err_reg;
  logic        range_err_reg;
  logic [1:0]  done_reg;
  logic        clr;

  assign setup      = psel && !penable;
  assign wr         = psel && penable && pready && pwrite;
  assign taddr      = pwdata[`TBL_ADDR_MSB:`TBL_ADDR_LSB];
  assign in_range   = taddr >= `HREG_FIRST && taddr <= `HREG_LAST;
  assign last_flags = count_reg != 16'h0000
                      && 32'(taddr) == 32'(`HREG_FIRST) + 32'(count_reg) * 32'(`ENTRY_WORDS);
  assign clr        = wr && paddr == `ADDR_STAT;

  // Bus answer, one access cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        case (paddr)
          `ADDR_CMD, `ADDR_TBL: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
          end
          `ADDR_STAT: begin
            prdata  <= {26'h0000000, done_reg, range_err_reg, cmd_err_reg, link.standby_flag};
            pslverr <= 1'b0;
          end
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Commands and table words onto the link
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link.cmd_valid <= 1'b0;
      link.cmd_code  <= 10'h000;
      link.cmd_coil  <= 1'b0;
      link.cmd_axis  <= 1'b0;
      link.tbl_we    <= 1'b0;
      link.tbl_addr  <= 11'h000;
      link.tbl_data  <= 16'h0000;
      link.tbl_store <= 1'b0;
      count_reg      <= 16'h0000;
    end else begin
      link.cmd_valid <= 1'b0;
      link.tbl_we    <= 1'b0;
      if (wr && paddr == `ADDR_CMD) begin  // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10
        link.cmd_valid <= 1'b1;
        link.cmd_code  <= pwdata[9:0];
        link.cmd_coil  <= pwdata[`CMD_COIL_BIT];
        link.cmd_axis  <= pwdata[`CMD_AXIS_BIT];
      end
      if (wr && paddr == `ADDR_TBL && in_range) begin  // R11
        link.tbl_we    <= 1'b1;
        link.tbl_addr  <= taddr;
        link.tbl_store <= pwdata[`TBL_STORE_BIT];
        link.tbl_data  <= last_flags ? (pwdata[15:0] & ~(16'h0001 << `F_CONT)) : pwdata[15:0];  // R16
        if (taddr == `HREG_FIRST) begin
          count_reg <= pwdata[15:0];
        end
      end
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_err_reg   <= 1'b0;
      range_err_reg <= 1'b0;
      done_reg      <= 2'h0;
    end else begin
      cmd_err_reg   <= link.cmd_err || (cmd_err_reg && !(clr && pwdata[`STAT_CMD_ERR]));
      range_err_reg <= (wr && paddr == `ADDR_TBL && !in_range)
                       || (range_err_reg && !(clr && pwdata[`STAT_RANGE_ERR]));
      done_reg      <= link.seq_done | (done_reg & ~({2{clr}} & pwdata[`STAT_DONE_LSB+1:`STAT_DONE_LSB]));
    end
  end

endmodule // seq_host
`default_nettype wire

// File: tb/seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module seq_chk (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        cmd_valid,
  input  wire logic [9:0]  cmd_code,
  input  wire logic        cmd_coil,
  input  wire logic        cmd_axis,
  input  wire logic        tbl_we,
  input  wire logic [10:0] tbl_addr,
  input  wire logic [1:0]  standby_flag,
  input  wire logic        cmd_err,
  input  wire logic [1:0]  seq_done
);
  logic [9:0] off;
  logic       is_run;
  logic       ax;

  // Run command decode and target axis
  assign off    = cmd_code - 10'h154;
  assign is_run = cmd_valid && (cmd_coil ? (off < 10'h008) : (cmd_code >= 10'h01E && cmd_code <= 10'h021));
  assign ax     = cmd_coil ? off[2] : cmd_axis;

  default clocking dclk @(posedge clk_sys); endclocking
  default disable iff (srst);

  tbl_range_a: assert property (tbl_we |-> tbl_addr >= 11'h1F4 && tbl_addr <= 11'h5DC)
    else $error("table write outside window");
  tbl_pulse_a: assert property (tbl_we |=> !tbl_we)
    else $error("table write not a pulse");
  cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command not a pulse");
  err_cause_a: assert property (cmd_err |-> $past(cmd_valid))
    else $error("error without command");
  start_busy_a: assert property (is_run && !standby_flag[ax] ##1 !standby_flag[$past(ax)] |-> cmd_err)
    else $error("busy start not refused");
  start_ok_a: assert property (is_run && standby_flag[ax] && $past(standby_flag[ax])
    |-> (##1 cmd_err) or (##2 !standby_flag[$past(ax, 2)]))
    else $error("idle start not taken");
  done_idle_a: assert property (seq_done[0] |-> !standby_flag[0] ##[1:2] standby_flag[0])
    else $error("done without return to idle");
  stop_fast_a: assert property (cmd_valid && cmd_coil && cmd_code == 10'h0F0 |-> ##[1:12] standby_flag[0])
    else $error("fast stop did not idle");
endmodule // seq_chk
`default_nettype wire

// File: tb/sequence_table_auto_mode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sequence_table_auto_mode_tb;
  logic             clk_sys = 1'b0;
  logic             srst = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [15:0]      init_velocity = 16'h0123;
  logic [1:0]       startup_run = 2'b00;
  logic [1:0]       fault_pin = 2'b00;
  logic [1:0]       pg_done = 2'b00;
  logic [1:0]       pg_hold = 2'b00;
  logic [1:0][2:0]  pd_sr = '0;
  logic [1:0]       pg_start, pg_stop_fast, pg_stop_dec;
  logic [1:0][15:0] pg_accel, pg_decel, pg_vel, pg_init_vel;
  logic [1:0][31:0] pg_target;
  logic [1:0][6:0]  pg_flags;
  logic [31:0]      rd;
  logic             er;
  int               num_errors = 0;
  int               num_checks = 0;
  int               waited = 0;

  always #10 clk_sys = ~clk_sys;

  seq_link_if lnk ();
  seq_host i_seq_host (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
  seq_device i_seq_device (.clk_sys(clk_sys), .srst(srst), .link(lnk), .init_velocity(init_velocity),
    .startup_run(startup_run), .fault_pin(fault_pin), .pg_done(pg_done), .pg_start(pg_start),
    .pg_stop_fast(pg_stop_fast), .pg_stop_dec(pg_stop_dec), .pg_accel(pg_accel), .pg_decel(pg_decel),
    .pg_vel(pg_vel), .pg_init_vel(pg_init_vel), .pg_target(pg_target), .pg_flags(pg_flags));
  seq_chk i_seq_chk (.clk_sys(clk_sys), .srst(srst), .cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code),
    .cmd_coil(lnk.cmd_coil), .cmd_axis(lnk.cmd_axis), .tbl_we(lnk.tbl_we), .tbl_addr(lnk.tbl_addr),
    .standby_flag(lnk.standby_flag), .cmd_err(lnk.cmd_err), .seq_done(lnk.seq_done));

  // Pulse generator: finishes 4 cycles after a start or stop unless held
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      pd_sr[i]   <= srst ? 3'h0 : {pd_sr[i][1:0], pg_start[i] | pg_stop_fast[i] | pg_stop_dec[i]};
      pg_done[i] <= !srst && pd_sr[i][2] && !pg_hold[i];
    end
  end

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_up(input string nm);
    num_errors++;
    $display("[FAIL] %s expected event seen timeout", nm);
    stop_test();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) give_up("apb ready");
  endtask

  task automatic cmd(input logic coil, input logic ax, input logic [9:0] code);
    apb(1'b1, 8'h00, {20'h0, ax, coil, code});
  endtask

  task automatic tbl_wr(input logic st, input logic [10:0] r, input logic [15:0] d);
    apb(1'b1, 8'h04, {4'h0, st, r, d});
  endtask

  // Kinds: 0 start, 1 done, 2 fast stop, 3 decelerated stop, 4 standby
  task automatic wait_ev(input int kind, input int ax);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 500 && !hit; n++) begin
      @(posedge clk_sys);
      #1;
      waited = n + 1;
      case (kind)
        0: hit = pg_start[ax] === 1'b1;
        1: hit = lnk.seq_done[ax] === 1'b1;
        2: hit = pg_stop_fast[ax] === 1'b1;
        3: hit = pg_stop_dec[ax] === 1'b1;
        default: hit = lnk.standby_flag[ax] === 1'b1;
      endcase
    end
    if (!hit) give_up("event wait");
  endtask

  function automatic logic [31:0] tgt(input logic inc, input int k);
    if (k == 0) return 32'h0000_0320;
    if (k == 1) return inc ? 32'h0000_0578 : 32'h0000_0258;
    return inc ? 32'h0000_04B0 : 32'hFFFF_FF38;
  endfunction

  task automatic load_tbl(input logic st, input logic inc);
    logic [31:0] t;
    tbl_wr(st, 11'h1F4, 16'h0003);
    for (int k = 0; k < 3; k++) begin
      t = tgt(1'b0, k);
      tbl_wr(st, 11'(501 + 6 * k), 16'h0100 + 16'(k));
      tbl_wr(st, 11'(502 + 6 * k), 16'h0200 + 16'(k));
      tbl_wr(st, 11'(503 + 6 * k), 16'h0300 + 16'(k));
      tbl_wr(st, 11'(504 + 6 * k), t[15:0]);
      tbl_wr(st, 11'(505 + 6 * k), t[31:16]);
      tbl_wr(st, 11'(506 + 6 * k), {9'h000, inc, 5'h1E, (!inc && k == 1)});
    end
  endtask

  task automatic prof(input logic ax, input logic inc, input int k);
    wait_ev(0, ax);
    if (k > 0) check("profile gap", inc ? 32'h0C : 32'h3E, 32'(waited));
    check("target", tgt(inc, k), pg_target[ax]);
    check("accel", 32'h0100 + k, 32'(pg_accel[ax]));
    check("decel", 32'h0200 + k, 32'(pg_decel[ax]));
    check("velocity", 32'h0300 + k, 32'(pg_vel[ax]));
    check("init velocity", 32'h0123, 32'(pg_init_vel[ax]));
    check("flags", {25'h0, inc, ((k == 2) ? 5'h1C : 5'h1E), (!inc && k == 1)}, 32'(pg_flags[ax]));
  endtask

  task automatic run(input logic coil, input logic ax, input logic [9:0] code, input logic inc,
                     input int passes, input logic [9:0] stop);
    cmd(coil, ax, code);
    for (int p = 0; p < passes; p++) begin
      for (int k = 0; k < 3; k++) prof(ax, inc, k);
    end
    if (stop == 10'h000) begin
      wait_ev(1, ax);
    end else begin
      pg_hold[ax] = 1'b1;
      cmd(coil, ax, stop);
      wait_ev((stop == 10'h012 || stop[9:1] == 9'h07A) ? 3 : 2, ax);
      pg_hold[ax] = 1'b0;
      wait_ev(4, ax);
    end
  endtask

  task automatic t_codes();
    run(1'b0, 1'b0, 10'h01E, 1'b1, 1, 10'h000);
    run(1'b0, 1'b1, 10'h01F, 1'b0, 1, 10'h000);
    run(1'b0, 1'b0, 10'h020, 1'b1, 2, 10'h011);
    run(1'b0, 1'b1, 10'h021, 1'b0, 2, 10'h012);
    $display("Test codes done");
  endtask

  task automatic t_coils();
    run(1'b1, 1'b0, 10'h154, 1'b1, 1, 10'h000);
    run(1'b1, 1'b1, 10'h158, 1'b1, 1, 10'h000);
    run(1'b1, 1'b0, 10'h155, 1'b1, 2, 10'h0F4);
    run(1'b1, 1'b1, 10'h159, 1'b1, 1, 10'h0F1);
    run(1'b1, 1'b0, 10'h156, 1'b0, 1, 10'h000);
    run(1'b1, 1'b1, 10'h15A, 1'b0, 1, 10'h000);
    run(1'b1, 1'b0, 10'h157, 1'b0, 2, 10'h0F0);
    run(1'b1, 1'b1, 10'h15B, 1'b0, 1, 10'h0F5);
    $display("Test coils done");
  endtask

  task automatic t_errors();
    cmd(1'b1, 1'b0, 10'h154);
    prof(1'b0, 1'b1, 0);
    pg_hold[0] = 1'b1;
    cmd(1'b0, 1'b0, 10'h01E);
    tbl_wr(1'b1, 11'h5DD, 16'h0000);
    apb(1'b0, 8'h08, 32'h0);
    check("busy start error", 32'h1, 32'(rd[2]));
    check("range error", 32'h1, 32'(rd[3]));
    check("standby A", 32'h0, 32'(rd[0]));
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped", 32'h1, 32'(er));
    apb(1'b1, 8'h08, 32'h0000_000C);
    apb(1'b0, 8'h08, 32'h0);
    check("error clear", 32'h0, 32'(rd[3:2]));
    run(1'b0, 1'b1, 10'h01F, 1'b0, 1, 10'h000);
    check("axis A still busy", 32'h0, 32'(lnk.standby_flag[0]));
    cmd(1'b0, 1'b0, 10'h011);
    wait_ev(2, 0);
    pg_hold[0] = 1'b0;
    wait_ev(4, 0);
    $display("Test errors done");
  endtask

  task automatic t_fault();
    cmd(1'b0, 1'b1, 10'h020);
    prof(1'b1, 1'b1, 0);
    pg_hold[1] = 1'b1;
    @(posedge clk_sys);
    fault_pin <= 2'b10;
    wait_ev(2, 1);
    pg_hold[1] = 1'b0;
    wait_ev(4, 1);
    @(posedge clk_sys);
    fault_pin <= 2'b00;
    repeat (4) @(posedge clk_sys);
    $display("Test fault done");
  endtask

  task automatic t_startup();
    @(posedge clk_sys);
    startup_run <= 2'b10;
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    for (int k = 0; k < 3; k++) prof(1'b1, 1'b1, k);
    wait_ev(1, 1);
    @(posedge clk_sys);
    startup_run <= 2'b00;
    $display("Test startup done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    load_tbl(1'b1, 1'b1);
    load_tbl(1'b0, 1'b0);
    t_codes();
    t_coils();
    t_errors();
    t_fault();
    t_startup();
    stop_test();
  end
endmodule // sequence_table_auto_mode_tb
`default_nettype wire
